/* File: mic_irq_ctrl.sv */
// Purpose: Interrupt controller of a three-axis magnetic sensor
// Assumes: Serial protocol decoded outside into a byte register port
// Notes: Flags refresh on a stored measurement set; latched flags also clear on a status read
// ==========================================================
// Overview of operation
// - Four sources, each separately enabled
// - Enabled condition sets its status flag
// - General pin active only when pin-enabled
// - Threshold/overflow to general pin, ready separate
// - Six active-low axis enables, reset disabled
// - One overflow pin enable, active high
// - Sample pin driven only when pin-enabled
// - Flags update with new stored data
// - Ready flag in resistance low byte
// - Disabled axis interrupt cleared after next measurement
// - Ready never latches, clears after readout
// - Non-latched flags follow each new measurement
// - Latched flags held until status read
// - Latch-select bit, reset selects latched
// - Per-pin polarity bits, default active high
// - Enabled pins push-pull, disabled high impedance
// - Ready fires after full set stored
// - Low flag when value below limit times 16
// - X/Y saturation value never trips low
// - High flag when value above limit times 16
// - Overflowed axis saturates to most negative
// - Overflow flag when any axis overflowed
`timescale 1ns/1ps
module mic_irq_ctrl (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire mic_pkg::mic_meas_s meas_i,
    input wire logic meas_valid_i,
    input wire logic readout_done_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [12:0] axis_x_value_o,
    output logic [12:0] axis_y_value_o,
    output logic [14:0] axis_z_value_o,
    output logic [13:0] plate_resistance_value_o,
    output mic_pkg::mic_pin_s int_pin_o,
    output mic_pkg::mic_pin_s new_sample_pin_o
);
    import mic_pkg::*;

    // ==========================================================
    // Threshold compare helpers
    function automatic logic [15:0] scale_limit(input logic [7:0] lim);
        scale_limit = {{4{lim[7]}}, lim, 4'h0};
    endfunction

    function automatic logic below(input logic [15:0] v, input logic [7:0] lim);
        below = $signed(v) < $signed(scale_limit(lim));
    endfunction

    function automatic logic above(input logic [15:0] v, input logic [7:0] lim);
        above = $signed(v) > $signed(scale_limit(lim));
    endfunction

    // ==========================================================
    // Configuration registers
    logic [7:0] axis_en_reg;
    logic [7:0] axis_en_next;
    logic [7:0] pin_cfg_reg;
    logic [7:0] pin_cfg_next;
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;
    logic latch_reg;
    logic latch_next;

    always_comb begin
        axis_en_next = axis_en_reg;
        pin_cfg_next = pin_cfg_reg;
        low_next = low_reg;
        high_next = high_reg;
        latch_next = latch_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                // axis enables in low six bits
                ADDR_AXIS_EN: axis_en_next = {1'b0, reg_wdata_i[6:0]};
                ADDR_PIN_CFG: pin_cfg_next = reg_wdata_i & 8'hc5;
                ADDR_LOW: low_next = reg_wdata_i;
                ADDR_HIGH: high_next = reg_wdata_i;
                ADDR_STATUS: latch_next = reg_wdata_i[LATCH_BIT];
                default: latch_next = latch_reg;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            axis_en_reg <= AXIS_EN_RST;
            pin_cfg_reg <= PIN_CFG_RST;
            low_reg <= LIMIT_RST;
            high_reg <= LIMIT_RST;
            latch_reg <= LATCH_RST;
        end else begin
            axis_en_reg <= axis_en_next;
            pin_cfg_reg <= pin_cfg_next;
            low_reg <= low_next;
            high_reg <= high_next;
            latch_reg <= latch_next;
        end
    end

    // ==========================================================
    // Saturation and condition evaluation
    logic [12:0] x_sat;
    logic [12:0] y_sat;
    logic [14:0] z_sat;
    logic [15:0] ax_val [3];
    logic [2:0] low_cond;
    logic [2:0] high_cond;
    logic ovf_cond;

    // overflowed axis takes most negative value
    assign x_sat = meas_i.ovf[0] ? SAT_XY : meas_i.x;
    assign y_sat = meas_i.ovf[1] ? SAT_XY : meas_i.y;
    assign z_sat = meas_i.ovf[2] ? SAT_Z : meas_i.z;
    // sign extension keeps two's complement order
    assign ax_val[0] = {{3{x_sat[12]}}, x_sat};
    assign ax_val[1] = {{3{y_sat[12]}}, y_sat};
    assign ax_val[2] = {z_sat[14], z_sat};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic sat_skip;
            // X/Y saturation excluded from low test
            assign sat_skip = (g < 2) && meas_i.ovf[g];
            // active-low enable, value below limit x16
            assign low_cond[g] = !axis_en_reg[g] && !sat_skip
                && below(ax_val[g], low_reg);
            // active-low enable, value above limit x16
            assign high_cond[g] = !axis_en_reg[g+3]
                && above(ax_val[g], high_reg);
        end
    endgenerate

    // any axis overflow raises the shared flag
    assign ovf_cond = |meas_i.ovf;

    // ==========================================================
    // Measurement data registers
    logic [12:0] x_reg;
    logic [12:0] x_next;
    logic [12:0] y_reg;
    logic [12:0] y_next;
    logic [14:0] z_reg;
    logic [14:0] z_next;
    logic [13:0] r_reg;
    logic [13:0] r_next;

    always_comb begin
        x_next = x_reg;
        y_next = y_reg;
        z_next = z_reg;
        r_next = r_reg;
        // whole set stored in one step
        if (meas_valid_i) begin
            x_next = x_sat;
            y_next = y_sat;
            z_next = z_sat;
            r_next = meas_i.r;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            x_reg <= '0;
            y_reg <= '0;
            z_reg <= '0;
            r_reg <= '0;
        end else begin
            x_reg <= x_next;
            y_reg <= y_next;
            z_reg <= z_next;
            r_reg <= r_next;
        end
    end

    assign axis_x_value_o = x_reg;
    assign axis_y_value_o = y_reg;
    assign axis_z_value_o = z_reg;
    assign plate_resistance_value_o = r_reg;

    // ==========================================================
    // Status flags
    logic [6:0] flags_reg;
    logic [6:0] flags_next;
    logic [6:0] cond;
    logic [6:0] keep_mask;
    logic stat_rd;
    logic sample_reg;
    logic sample_next;

    assign cond = {ovf_cond, high_cond, low_cond};
    // Disabled axes lose their flag on the next sample
    assign keep_mask = {1'b1, ~axis_en_reg[5:0]};
    assign stat_rd = reg_rd_i && (reg_addr_i == ADDR_STATUS);

    always_comb begin
        flags_next = flags_reg;
        if (latch_reg) begin
            if (stat_rd) begin
                flags_next = FLAGS_RST;
            end
            // a fresh condition wins over the clear
            if (meas_valid_i) begin
                flags_next = (flags_next & keep_mask) | cond;
            end
        end else if (meas_valid_i) begin
            flags_next = cond;
        end
    end

    always_comb begin
        sample_next = sample_reg;
        // cleared by end of readout, never latched
        if (readout_done_i) begin
            sample_next = 1'b0;
        end
        // new full set marks ready, set wins
        if (meas_valid_i) begin
            sample_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= FLAGS_RST;
            sample_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            sample_reg <= sample_next;
        end
    end

    // ==========================================================
    // Interrupt pins
    logic int_active;
    mic_pin_s int_pin_reg;
    mic_pin_s int_pin_next;
    mic_pin_s sample_pin_reg;
    mic_pin_s sample_pin_next;

    // thresholds and gated overflow feed general pin
    // threshold flags feed it ungated, overflow only with its own enable
    assign int_active = (|flags_reg[5:0])
        || (flags_reg[STAT_OVF_BIT] && axis_en_reg[OVF_EN_BIT]);

    always_comb begin
        // driven only with pin enable set
        int_pin_next.oe_n = !pin_cfg_reg[INT_PIN_EN_BIT];
        // polarity bit one means active high
        int_pin_next.level = pin_cfg_reg[INT_PIN_EN_BIT]
            && (int_active == pin_cfg_reg[INT_POL_BIT]);
        // sample pin gated by its own enable
        sample_pin_next.oe_n = !pin_cfg_reg[SAMPLE_PIN_EN_BIT];
        // ready goes to its own pin
        sample_pin_next.level = pin_cfg_reg[SAMPLE_PIN_EN_BIT]
            && (sample_reg == pin_cfg_reg[SAMPLE_POL_BIT]);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
            sample_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
        end else begin
            int_pin_reg <= int_pin_next;
            sample_pin_reg <= sample_pin_next;
        end
    end

    assign int_pin_o = int_pin_reg;
    assign new_sample_pin_o = sample_pin_reg;

    // ==========================================================
    // Register readback
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            case (reg_addr_i)
                // ready flag beside resistance low bits
                ADDR_RES_LSB: rdata_next = {r_reg[5:0], 1'b0, sample_reg};
                ADDR_STATUS: rdata_next = {1'b0, flags_reg};
                ADDR_AXIS_EN: rdata_next = axis_en_reg;
                ADDR_PIN_CFG: rdata_next = pin_cfg_reg;
                ADDR_LOW: rdata_next = low_reg;
                ADDR_HIGH: rdata_next = high_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_low_flag_set: assert property (
        meas_valid_i && low_cond[0] |=> flags_reg[0]
    ) else $error("low flag not set");

    a_nonlatch_follow: assert property (
        meas_valid_i && !latch_reg |=> flags_reg == $past(cond)
    ) else $error("non-latched flags do not follow condition");

    a_latch_hold: assert property (
        latch_reg && !meas_valid_i && !stat_rd
        |=> flags_reg == $past(flags_reg)
    ) else $error("latched flags changed without cause");

    a_status_read_clear: assert property (
        latch_reg && stat_rd && !meas_valid_i |=> flags_reg == 7'h00
    ) else $error("status read did not clear flags");

    a_disabled_clear: assert property (
        meas_valid_i && axis_en_reg[3] |=> !flags_reg[3]
    ) else $error("disabled flag survived a measurement");

    a_int_hiz: assert property (
        !pin_cfg_reg[INT_PIN_EN_BIT] |=> int_pin_o.oe_n
    ) else $error("general pin driven while disabled");

    a_ready_set: assert property (
        meas_valid_i |=> sample_reg ##1 new_sample_pin_o.level
            == ($past(pin_cfg_reg[SAMPLE_PIN_EN_BIT]) && $past(pin_cfg_reg[SAMPLE_POL_BIT]))
    ) else $error("ready not raised after new set");

    a_ready_clear: assert property (
        readout_done_i && !meas_valid_i |=> !sample_reg
    ) else $error("ready not cleared after readout");

    a_sat_value: assert property (
        meas_valid_i && meas_i.ovf[2] |=> axis_z_value_o == SAT_Z
    ) else $error("z axis not saturated on overflow");

    a_no_low_sat: assert property (
        meas_valid_i && meas_i.ovf[1] |-> !low_cond[1]
    ) else $error("saturated y tripped low threshold");

    a_ovf_flag: assert property (
        meas_valid_i && (|meas_i.ovf) |=> flags_reg[STAT_OVF_BIT]
    ) else $error("overflow flag missing");

    a_int_level: assert property (
        pin_cfg_reg[INT_PIN_EN_BIT]
        |=> int_pin_o.level == ($past(int_active) == $past(pin_cfg_reg[INT_POL_BIT]))
    ) else $error("general pin level wrong");

    c_latched_read: cover property (
        latch_reg && flags_reg != 7'h00 ##1 stat_rd
    );
    c_nonlatch_drop: cover property (
        !latch_reg && flags_reg[0] ##1 meas_valid_i && !low_cond[0]
    );
    c_ready_cycle: cover property (
        meas_valid_i ##[1:20] readout_done_i
    );
endmodule

/* File: mic_pkg.sv */
// Purpose: Constants and carriers for the magnetometer interrupt controller
// Assumes: 8-bit register space, one 50 MHz clock
// Notes: Register offsets are byte addresses of the serial register map
package mic_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_RES_LSB = 8'h48;
    localparam logic [7:0] ADDR_STATUS = 8'h4a;
    localparam logic [7:0] ADDR_AXIS_EN = 8'h4d;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h4e;
    localparam logic [7:0] ADDR_LOW = 8'h4f;
    localparam logic [7:0] ADDR_HIGH = 8'h50;
    // ==========================================================
    // Field positions
    localparam int STAT_OVF_BIT = 6;
    localparam int STAT_HIGH_LSB = 3;
    localparam int LATCH_BIT = 1;
    localparam int OVF_EN_BIT = 6;
    localparam int SAMPLE_PIN_EN_BIT = 7;
    localparam int INT_PIN_EN_BIT = 6;
    localparam int SAMPLE_POL_BIT = 2;
    localparam int INT_POL_BIT = 0;
    localparam int SAMPLE_FLAG_BIT = 0;
    localparam int THR_SHIFT = 4;
    // ==========================================================
    // Values after reset
    localparam logic [7:0] AXIS_EN_RST = 8'h3f;
    localparam logic [7:0] PIN_CFG_RST = 8'h05;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam logic LATCH_RST = 1'b1;
    localparam logic [6:0] FLAGS_RST = 7'h00;
    // ==========================================================
    // Saturation values on overflow
    localparam logic [12:0] SAT_XY = 13'h1000;
    localparam logic [14:0] SAT_Z = 15'h4000;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [12:0] x;
        logic [12:0] y;
        logic [14:0] z;
        logic [13:0] r;
        logic [2:0] ovf;
    } mic_meas_s;
    typedef struct packed {
        logic level;
        logic oe_n;
    } mic_pin_s;
endpackage

/* File: mic_host_model.sv */
// Purpose: Host side view of the two interrupt pins as wires
// Assumes: No pull resistor on either pin
// Notes: A released pin shows a changing pattern, never a stale level
`timescale 1ns/1ps
module mic_host_model (
    input wire logic clock_i,
    input wire mic_pkg::mic_pin_s int_pin_i,
    input wire mic_pkg::mic_pin_s sample_pin_i,
    output logic int_wire_o,
    output logic sample_wire_o
);
    import mic_pkg::*;
    logic float_reg = 1'b0;
    // ==========================================================
    // Floating pattern
    always @(posedge clock_i) begin
        float_reg <= ~float_reg;
    end
    // ==========================================================
    // Wire resolution
    // driven level when enabled, high-Z pattern otherwise
    assign int_wire_o = int_pin_i.oe_n ? float_reg : int_pin_i.level;
    assign sample_wire_o = sample_pin_i.oe_n ? ~float_reg : sample_pin_i.level;
endmodule

/* File: magnetometer_interrupt_controller_bench.sv */
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Host decoded to byte strobes; pins observed through host model
// Notes: Table rows run in non-latched mode so status reads do not clear
`timescale 1ns/1ps
module magnetometer_interrupt_controller_bench;
    import mic_pkg::*;
    typedef struct packed {
        logic [7:0] en, lo, hi;
        logic [12:0] x, y;
        logic [14:0] z;
        logic [2:0] ovf;
        logic [7:0] st;
        logic [12:0] ex;
        logic [14:0] ez;
    } mic_row_s;
    logic clock_i, rst_n_i, meas_valid_i, readout_done_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    mic_meas_s meas_i;
    logic [12:0] axis_x_value_o, axis_y_value_o;
    logic [14:0] axis_z_value_o;
    logic [13:0] plate_resistance_value_o;
    mic_pin_s int_pin_o, new_sample_pin_o;
    logic int_wire, sample_wire;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    mic_row_s rows [6];
    mic_irq_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .meas_i(meas_i),
        .meas_valid_i(meas_valid_i), .readout_done_i(readout_done_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .axis_x_value_o(axis_x_value_o),
        .axis_y_value_o(axis_y_value_o), .axis_z_value_o(axis_z_value_o),
        .plate_resistance_value_o(plate_resistance_value_o), .int_pin_o(int_pin_o),
        .new_sample_pin_o(new_sample_pin_o));
    mic_host_model i_host (.clock_i(clock_i), .int_pin_i(int_pin_o),
        .sample_pin_i(new_sample_pin_o), .int_wire_o(int_wire),
        .sample_wire_o(sample_wire));
    // ==========================================================
    // Clock and timeout
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic meas(input logic [12:0] x, input logic [14:0] z, input logic [2:0] ovf,
            input logic [12:0] y = 13'h0000);
        @(posedge clock_i);
        meas_i <= '{x: x, y: y, z: z, r: 14'h0015, ovf: ovf};
        meas_valid_i <= 1'b1;
        @(posedge clock_i);
        meas_valid_i <= 1'b0;
    endtask
    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        meas_valid_i = 1'b0;
        readout_done_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        meas_i = '0;
        rows[0] = '{8'h00, 8'h00, 8'h00, 13'h1f9c, 13'h0005, 15'h0000, 3'h0, 8'h11,
            13'h1f9c, 15'h0000};
        rows[1] = '{8'h3f, 8'h00, 8'h00, 13'h1f9c, 13'h0005, 15'h0000, 3'h0, 8'h00,
            13'h1f9c, 15'h0000};
        rows[2] = '{8'h00, 8'h00, 8'h00, 13'h0123, 13'h0000, 15'h0000, 3'h1, 8'h40,
            13'h1000, 15'h0000};
        rows[3] = '{8'h00, 8'h00, 8'h00, 13'h0000, 13'h0000, 15'h0123, 3'h4, 8'h44,
            13'h0000, 15'h4000};
        rows[4] = '{8'h00, 8'h02, 8'h02, 13'h0020, 13'h001f, 15'h0021, 3'h0, 8'h22,
            13'h0020, 15'h0021};
        rows[5] = '{8'h00, 8'hff, 8'hfe, 13'h1fef, 13'h1ff0, 15'h7fdf, 3'h0, 8'h1d,
            13'h1fef, 15'h7fdf};
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        wr(ADDR_STATUS, 8'h00);
        foreach (rows[i]) begin
            wr(ADDR_AXIS_EN, rows[i].en);
            wr(ADDR_LOW, rows[i].lo);
            wr(ADDR_HIGH, rows[i].hi);
            meas(rows[i].x, rows[i].z, rows[i].ovf, rows[i].y);
            rd(ADDR_STATUS, d);
            check(d, rows[i].st);
            check(axis_x_value_o, rows[i].ex);
            check(axis_z_value_o, rows[i].ez);
            check(int_pin_o, 2'h1);
            check(new_sample_pin_o, 2'h1);
        end
        // Second reset in mid-run, then reset values
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(ADDR_AXIS_EN, d);
        check(d, 8'h3f);
        rd(ADDR_PIN_CFG, d);
        check(d, 8'h05);
        rd(ADDR_LOW, d);
        check(d, 8'h00);
        rd(8'h4b, d);
        check(d, 8'h00);
        // Latched default, pins enabled active high
        wr(ADDR_PIN_CFG, 8'hc5);
        wr(ADDR_AXIS_EN, 8'h3e);
        meas(13'h1f9c, 15'h0000, 3'h0);
        settle();
        check(int_pin_o, 2'h2);
        check(int_wire, 1'b1);
        check(new_sample_pin_o, 2'h2);
        meas(13'h0064, 15'h0000, 3'h0);
        settle();
        check(int_pin_o, 2'h2);
        rd(ADDR_RES_LSB, d);
        check(d, 8'h55);
        @(posedge clock_i);
        readout_done_i <= 1'b1;
        @(posedge clock_i);
        readout_done_i <= 1'b0;
        settle();
        check(new_sample_pin_o, 2'h0);
        rd(ADDR_STATUS, d);
        check(d, 8'h01);
        rd(ADDR_STATUS, d);
        check(d, 8'h00);
        settle();
        check(int_pin_o, 2'h0);
        // Active low polarity on both pins
        wr(ADDR_PIN_CFG, 8'hc0);
        settle();
        settle();
        check(int_pin_o, 2'h2);
        meas(13'h0064, 15'h0000, 3'h0);
        settle();
        check(new_sample_pin_o, 2'h0);
        check(sample_wire, 1'b0);
        // Overflow routed to the general pin by its own enable
        wr(ADDR_PIN_CFG, 8'hc5);
        wr(ADDR_AXIS_EN, 8'h7f);
        meas(13'h0000, 15'h0000, 3'h2);
        settle();
        check(int_pin_o, 2'h2);
        check(axis_y_value_o, 13'h1000);
        check(plate_resistance_value_o, 14'h0015);
        rd(ADDR_STATUS, d);
        check(d, 8'h40);
        results();
    end
endmodule
